// ### logic/ccom_params.svh
/*
  Constants of the counter control override block: register offsets,
  field positions, reset values and timing counts.
  Assumes a 100 MHz module clock and APB access with 32-bit data.
*/
// Contract
// [RQ1] Override settings apply only while the master override bit is one; code gates only the select and frequency bits.
// [RQ2] Two select bits per external pin; pins a0/a1 feed A, b0/b1 feed B.
// [RQ3] Pin code 00 latch, 01 clear, 10 enable, 11 load; else ladder bit.
// [RQ4] Both pins on same nonzero code force that control low.
// [RQ5] Counter B uses identical mapping with its own pins and ladder bits.
// [RQ6] Frequency bits: 00 totalizer, A only, B only, both alternate.
// [RQ7] Filter code: 00 1MHz, 01 100KHz, high bit set 10KHz.
// [RQ8] Two threshold bits pass to the comparator as a code.
// [RQ9] Trigger rising edge starts one-shot; ignored while pulse runs.
// [RQ10] Mode bit set selects one-shot, clear runs continuous PWM.
// [RQ11] Times count in 100ns units, times 16 when prescale set.
// [RQ12] Route bit set drives output 1 from generator A, else ladder bit.
// [RQ13] Channel B mirrors A with its own bits onto output 4.
// [RQ14] Ladder keeps A high word no longer than A period word.
// [RQ15] Ladder keeps B high word no longer than B period word.
// [RQ16] Live PWM A and B levels are readable status bits.
// [RQ17] Ladder bits and pins are synchronised; edges compare successive samples.
`ifndef CCOM_PARAMS_SVH
`define CCOM_PARAMS_SVH
`define CCOM_ADDR_CTRL 12'h000
`define CCOM_ADDR_PULSE 12'h004
`define CCOM_ADDR_A_PERIOD 12'h008
`define CCOM_ADDR_A_HIGH 12'h00C
`define CCOM_ADDR_B_PERIOD 12'h010
`define CCOM_ADDR_B_HIGH 12'h014
`define CCOM_ADDR_STATUS 12'h018
// CTRL fields
`define CCOM_F_OVERRIDE 0
`define CCOM_F_FREQ_A 1
`define CCOM_F_FREQ_B 2
`define CCOM_F_LADDER_A 4
`define CCOM_F_LADDER_B 8
`define CCOM_F_SEL_A 12
`define CCOM_F_SEL_B 16
`define CCOM_F_THRESH 20
`define CCOM_F_FILTER 22
// PULSE fields, per channel base 0 (A) and 8 (B)
`define CCOM_F_TRIG 0
`define CCOM_F_MODE 1
`define CCOM_F_PRESC 2
`define CCOM_F_ROUTE 3
`define CCOM_F_LOUT 4
`define CCOM_CH_STRIDE 8
`define CCOM_RST_WORD 32'h0000_0000
`define CCOM_UNIT_NS 100
`define CCOM_CLK_NS 10
`define CCOM_UNIT_CYC (`CCOM_UNIT_NS / `CCOM_CLK_NS)
`define CCOM_PRESC_MUL 16
`endif

// ### logic/ccom_pkg.sv
/*
  Types of the counter control override block.
  Assumes ccom_params.svh for constants.
*/
package ccom_pkg;
  typedef struct packed {
    logic load;
    logic enable;
    logic clear;
    logic latch;
  } ccom_ctrl_t;
  typedef enum logic [3:0] {
    CCOM_FREQ_TOTAL = 4'b0001,
    CCOM_FREQ_A = 4'b0010,
    CCOM_FREQ_B = 4'b0100,
    CCOM_FREQ_ALT = 4'b1000
  } ccom_freq_t;
  typedef enum logic [2:0] {
    CCOM_FLT_1MHZ = 3'b001,
    CCOM_FLT_100KHZ = 3'b010,
    CCOM_FLT_10KHZ = 3'b100
  } ccom_filt_t;
  typedef enum logic [2:0] {
    CCOM_PG_PWM = 3'b001,
    CCOM_PG_IDLE = 3'b010,
    CCOM_PG_SHOT = 3'b100
  } ccom_pg_t;
  typedef struct packed {
    ccom_pg_t st;
    logic [15:0] cnt;
    logic [7:0] pre;
    logic out;
    logic trig_q;
  } ccom_gen_t;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] pulse;
    logic [15:0] per_a;
    logic [15:0] hi_a;
    logic [15:0] per_b;
    logic [15:0] hi_b;
  } ccom_regs_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ccom_apb_rsp_t;
endpackage

// ### logic/ccom_override.sv
/*
  Runtime override map for a dual counter with two pulse generators.
  Registers over APB; pins arrive asynchronously and are synchronised.
*/
`timescale 1ns/1ps
`include "ccom_params.svh"
module ccom_override #(
  parameter int PW = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output ccom_pkg::ccom_apb_rsp_t apb_rsp,
  // External control pins
  input wire logic ext_ctrl_pin_a0,
  input wire logic ext_ctrl_pin_a1,
  input wire logic ext_ctrl_pin_b0,
  input wire logic ext_ctrl_pin_b1,
  // Stored power-up configuration
  input wire logic [3:0] cfg_sel_a,
  input wire logic [3:0] cfg_sel_b,
  input wire logic [1:0] cfg_freq,
  // Counter controls and conditioning
  output ccom_pkg::ccom_ctrl_t ctrl_a,
  output ccom_pkg::ccom_ctrl_t ctrl_b,
  output ccom_pkg::ccom_freq_t freq_mode,
  output ccom_pkg::ccom_filt_t filter_mode,
  output logic [1:0] threshold_code,
  // Outputs
  output logic out1,
  output logic out4
);
  import ccom_pkg::*;

  // Counter width is fixed by the 16-bit period and high words
  if (PW != 16) begin : g_pw_check
    $error("ccom_override: PW must be 16");
  end

  typedef struct packed {
    ccom_regs_t r;
    ccom_apb_rsp_t rsp;
    logic [3:0] pin_m;
    logic [3:0] pin_s;
    ccom_gen_t ga;
    ccom_gen_t gb;
    ccom_ctrl_t ca;
    ccom_ctrl_t cb;
    ccom_freq_t fm;
    ccom_filt_t flt;
    logic [1:0] thr;
    logic o1;
    logic o4;
  } st_t;

  st_t s_q, s_d;

  // Pin mapping for one counter
  function automatic ccom_ctrl_t map_ctrl(input logic [3:0] sel, input logic [3:0] lad,
                                          input logic p0, input logic p1);
    logic [3:0] v;
    v = lad; // [RQ3]
    for (int c = 0; c < 4; c++) begin
      if (sel[3:2] == c[1:0] && sel[1:0] == c[1:0] && sel != 4'h0) begin
        v[c] = 1'b0; // [RQ4]
      end else if (sel != 4'h0) begin
        if (sel[3:2] == c[1:0]) v[c] = p0; // [RQ2]
        if (sel[1:0] == c[1:0]) v[c] = p1;
      end
    end
    // v index: 0 latch, 1 clear, 2 enable, 3 load
    map_ctrl = '{load: v[3], enable: v[2], clear: v[1], latch: v[0]};
  endfunction

  // One pulse generator step
  function automatic ccom_gen_t gen_step(input ccom_gen_t g, input logic [7:0] bits,
                                         input logic [15:0] per, input logic [15:0] hi);
    ccom_gen_t n;
    logic [7:0] lim;
    logic tick;
    n = g;
    lim = bits[`CCOM_F_PRESC] ? 8'(`CCOM_UNIT_CYC * `CCOM_PRESC_MUL - 1)
                              : 8'(`CCOM_UNIT_CYC - 1); // [RQ11]
    tick = (g.pre >= lim);
    n.pre = tick ? 8'h00 : g.pre + 8'h01;
    n.trig_q = bits[`CCOM_F_TRIG]; // [RQ17]
    case (g.st)
      CCOM_PG_PWM: begin
        if (bits[`CCOM_F_MODE]) begin
          n.st = CCOM_PG_IDLE; // [RQ10]
          n.out = 1'b0;
        end else if (tick) begin
          n.cnt = (g.cnt + 16'h0001 >= per) ? 16'h0000 : g.cnt + 16'h0001;
          n.out = (n.cnt < hi);
        end
      end
      CCOM_PG_IDLE: begin
        n.out = 1'b0;
        if (!bits[`CCOM_F_MODE]) begin
          n.st = CCOM_PG_PWM;
          n.cnt = 16'h0000;
        end else if (bits[`CCOM_F_TRIG] && !g.trig_q && hi != 16'h0000) begin
          n.st = CCOM_PG_SHOT; // [RQ9]
          n.cnt = 16'h0000;
          n.pre = 8'h00;
          n.out = 1'b1;
        end
      end
      CCOM_PG_SHOT: begin
        if (tick) begin
          n.cnt = g.cnt + 16'h0001;
          if (g.cnt + 16'h0001 >= hi) begin
            n.st = CCOM_PG_IDLE; // [RQ9]
            n.out = 1'b0;
          end
        end
      end
      default: n.st = CCOM_PG_IDLE;
    endcase
    gen_step = n;
  endfunction

  logic wr_en;
  logic rd_en;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  always_comb begin
    logic ovr;
    logic [3:0] sa;
    logic [3:0] sb;
    logic [1:0] fq;
    logic [31:0] rd;
    ovr = 1'b0;
    sa = 4'h0;
    sb = 4'h0;
    fq = 2'b00;
    rd = 32'h0000_0000;
    s_d = s_q;
    s_d.pin_m = {ext_ctrl_pin_b1, ext_ctrl_pin_b0, ext_ctrl_pin_a1, ext_ctrl_pin_a0}; // [RQ17]
    s_d.pin_s = s_q.pin_m;
    s_d.rsp.pready = 1'b1;
    s_d.rsp.pslverr = 1'b0;
    if (wr_en) begin
      if (paddr == `CCOM_ADDR_CTRL) begin
        s_d.r.ctrl = pwdata;
      end else if (paddr == `CCOM_ADDR_PULSE) begin
        s_d.r.pulse = pwdata;
      end else if (paddr == `CCOM_ADDR_A_PERIOD) begin
        s_d.r.per_a = pwdata[15:0];
      end else if (paddr == `CCOM_ADDR_A_HIGH) begin
        s_d.r.hi_a = pwdata[15:0];
      end else if (paddr == `CCOM_ADDR_B_PERIOD) begin
        s_d.r.per_b = pwdata[15:0];
      end else if (paddr == `CCOM_ADDR_B_HIGH) begin
        s_d.r.hi_b = pwdata[15:0];
      end else if (paddr != `CCOM_ADDR_STATUS) begin
        s_d.rsp.pslverr = 1'b1;
      end
    end
    if (rd_en) begin
      if (paddr == `CCOM_ADDR_CTRL) begin
        rd = s_q.r.ctrl;
      end else if (paddr == `CCOM_ADDR_PULSE) begin
        rd = s_q.r.pulse;
      end else if (paddr == `CCOM_ADDR_A_PERIOD) begin
        rd = {16'h0000, s_q.r.per_a};
      end else if (paddr == `CCOM_ADDR_A_HIGH) begin
        rd = {16'h0000, s_q.r.hi_a};
      end else if (paddr == `CCOM_ADDR_B_PERIOD) begin
        rd = {16'h0000, s_q.r.per_b};
      end else if (paddr == `CCOM_ADDR_B_HIGH) begin
        rd = {16'h0000, s_q.r.hi_b};
      end else if (paddr == `CCOM_ADDR_STATUS) begin
        rd = {30'h0000_0000, s_q.gb.out, s_q.ga.out}; // [RQ16]
      end
      s_d.rsp.prdata = rd;
    end
    // Override or stored configuration
    ovr = s_q.r.ctrl[`CCOM_F_OVERRIDE];
    sa = ovr ? s_q.r.ctrl[`CCOM_F_SEL_A +: 4] : cfg_sel_a; // [RQ1]
    sb = ovr ? s_q.r.ctrl[`CCOM_F_SEL_B +: 4] : cfg_sel_b;
    fq = ovr ? s_q.r.ctrl[`CCOM_F_FREQ_A +: 2] : cfg_freq;
    s_d.ca = map_ctrl(sa, s_q.r.ctrl[`CCOM_F_LADDER_A +: 4], s_q.pin_s[0], s_q.pin_s[1]); // [RQ3]
    s_d.cb = map_ctrl(sb, s_q.r.ctrl[`CCOM_F_LADDER_B +: 4], s_q.pin_s[2], s_q.pin_s[3]); // [RQ5]
    case (fq)
      2'b00: s_d.fm = CCOM_FREQ_TOTAL; // [RQ6]
      2'b01: s_d.fm = CCOM_FREQ_A;
      2'b10: s_d.fm = CCOM_FREQ_B;
      default: s_d.fm = CCOM_FREQ_ALT;
    endcase
    if (s_q.r.ctrl[`CCOM_F_FILTER + 1]) begin
      s_d.flt = CCOM_FLT_10KHZ; // [RQ7]
    end else if (s_q.r.ctrl[`CCOM_F_FILTER]) begin
      s_d.flt = CCOM_FLT_100KHZ;
    end else begin
      s_d.flt = CCOM_FLT_1MHZ;
    end
    s_d.thr = s_q.r.ctrl[`CCOM_F_THRESH +: 2]; // [RQ8]
    s_d.ga = gen_step(s_q.ga, s_q.r.pulse[7:0], s_q.r.per_a, s_q.r.hi_a);
    s_d.gb = gen_step(s_q.gb, s_q.r.pulse[15:8], s_q.r.per_b, s_q.r.hi_b); // [RQ13]
    s_d.o1 = s_q.r.pulse[`CCOM_F_ROUTE] ? s_q.ga.out : s_q.r.pulse[`CCOM_F_LOUT]; // [RQ12]
    s_d.o4 = s_q.r.pulse[`CCOM_CH_STRIDE + `CCOM_F_ROUTE] ? s_q.gb.out
           : s_q.r.pulse[`CCOM_CH_STRIDE + `CCOM_F_LOUT]; // [RQ13]
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.ga.st <= CCOM_PG_PWM;
      s_q.gb.st <= CCOM_PG_PWM;
      s_q.fm <= CCOM_FREQ_TOTAL;
      s_q.flt <= CCOM_FLT_1MHZ;
    end else begin
      s_q <= s_d;
    end
  end

  assign apb_rsp = s_q.rsp;
  assign ctrl_a = s_q.ca;
  assign ctrl_b = s_q.cb;
  assign freq_mode = s_q.fm;
  assign filter_mode = s_q.flt;
  assign threshold_code = s_q.thr;
  assign out1 = s_q.o1;
  assign out4 = s_q.o4;

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence trig_rise_s(logic g_idle, logic t, logic tq);
    g_idle && t && !tq;
  endsequence

  route_a_out_a: assert property (s_q.r.pulse[`CCOM_F_ROUTE] // [RQ12]
                                  |=> out1 == $past(s_q.ga.out))
    else $error("out1 not from generator A");
  route_b_out_a: assert property (!s_q.r.pulse[11] |=> out4 == $past(s_q.r.pulse[12])) // [RQ13]
    else $error("out4 not from ladder bit");
  override_sel_a: assert property (!s_q.r.ctrl[0] && cfg_sel_a == 4'h0 // [RQ1]
                                   |=> ctrl_a == $past(s_q.r.ctrl[7:4]))
    else $error("stored config not used");
  conflict_zero_a: assert property (s_q.r.ctrl[0] && s_q.r.ctrl[15:12] == 4'hF // [RQ4]
                                    |=> !ctrl_a.load)
    else $error("conflicting load not forced low");
  filter_low_a: assert property (s_q.r.ctrl[23] |=> filter_mode == CCOM_FLT_10KHZ) // [RQ7]
    else $error("filter code wrong");
  thresh_pass_a: assert property (1'b1 |=> threshold_code == $past(s_q.r.ctrl[21:20])) // [RQ8]
    else $error("threshold code wrong");
  shot_start_a: assert property (trig_rise_s(s_q.ga.st == CCOM_PG_IDLE && s_q.r.pulse[1] // [RQ9]
                                 && s_q.r.hi_a != 16'h0000, s_q.r.pulse[0], s_q.ga.trig_q)
                                 |=> s_q.ga.out)
    else $error("one-shot not started");
  mode_stop_a: assert property (s_q.r.pulse[1] && s_q.ga.st == CCOM_PG_PWM // [RQ10]
                                |=> s_q.ga.st == CCOM_PG_IDLE && !s_q.ga.out)
    else $error("PWM not stopped");
  freq_dec_a: assert property (s_q.r.ctrl[2:0] == 3'b111 |=> freq_mode == CCOM_FREQ_ALT) // [RQ6]
    else $error("alternate mode not decoded");
  pin_map_b: assert property (s_q.r.ctrl[0] && s_q.r.ctrl[19:16] == 4'b0001 // [RQ5]
                              |=> ctrl_b.latch == $past(s_q.pin_s[2]))
    else $error("pin b0 not on latch");
endmodule // ccom_override

// ### tb/ccom_ladder_model.sv
/*
  Ladder program model: writes and reads the block's registers over APB.
  Assumes one clock shared with the block; callers wait for each task.
*/
`timescale 1ns/1ps
module ccom_ladder_model (
  // Clock and response
  input wire logic clk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  // Request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines flip so a stale value never looks valid
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // ccom_ladder_model

// ### tb/ccom_override_bench.sv
/*
  Self-checking bench: control mapping, conditioning codes and pulse outputs.
  Assumes ccom_ladder_model as bus master and default block parameters.
*/
`timescale 1ns/1ps
`include "ccom_params.svh"
module ccom_override_bench;
  import ccom_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel, penable, pwrite, out1, out4;
  logic meas = 1'b0;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [31:0] seed = 32'hFC62F121;
  logic [3:0] pin = 4'h0;
  logic [3:0] cfg_a = 4'h0;
  logic [3:0] cfg_b = 4'h0;
  logic [1:0] cfg_f = 2'b00;
  logic [1:0] thr;
  ccom_apb_rsp_t rsp;
  ccom_ctrl_t ctrl_a, ctrl_b;
  ccom_freq_t freq_mode;
  ccom_filt_t filter_mode;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;
  int n1, n4;
  always #5 clk = ~clk;
  ccom_override dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .apb_rsp(rsp),
    .ext_ctrl_pin_a0(pin[0]), .ext_ctrl_pin_a1(pin[1]), .ext_ctrl_pin_b0(pin[2]),
    .ext_ctrl_pin_b1(pin[3]), .cfg_sel_a(cfg_a), .cfg_sel_b(cfg_b), .cfg_freq(cfg_f),
    .ctrl_a(ctrl_a), .ctrl_b(ctrl_b), .freq_mode(freq_mode), .filter_mode(filter_mode),
    .threshold_code(thr), .out1(out1), .out4(out4));
  ccom_ladder_model ladder (.clk(clk), .pready(rsp.pready), .prdata(rsp.prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction

  // Pin code picks the control bit; equal nonzero codes clear it
  function automatic logic [3:0] map(input logic [3:0] sel, input logic p0, input logic p1,
                                     input logic [3:0] lad);
    logic [3:0] r;
    r = lad;
    if (sel != 4'h0 && sel[3:2] == sel[1:0]) begin
      r[sel[1:0]] = 1'b0;
    end else if (sel != 4'h0) begin
      r[sel[3:2]] = p0;
      r[sel[1:0]] = p1;
    end
    return r;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    ladder.xfer(1'b1, a, d, rd);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    ladder.xfer(1'b0, a, 32'h0000_0000, rd);
    check(rd, exp);
  endtask

  task automatic wrap_up;
    if (n_fail == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (meas) begin
      n1 += out1;
      n4 += out4;
    end
    if (cycles == 60000) begin
      n_fail++;
      wrap_up();
    end
  end

  initial begin
    logic [31:0] c, m;
    logic [15:0] p, h, hb;
    int u;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    check(freq_mode, CCOM_FREQ_TOTAL);
    check(filter_mode, CCOM_FLT_1MHZ);
    wr(`CCOM_ADDR_A_PERIOD, 32'hFFFF_0005);
    rdc(`CCOM_ADDR_A_PERIOD, 32'h0000_0005);
    wr(`CCOM_ADDR_STATUS, 32'hFFFF_FFFF);
    // Error flag stands for the cycle after the access edge
    @(negedge clk);
    check(rsp.pslverr, 32'h0000_0000);
    wr(12'h01C, 32'hFFFF_FFFF);
    @(negedge clk);
    check(rsp.pslverr, 32'h0000_0001);
    rdc(`CCOM_ADDR_STATUS, 32'h0000_0000);
    rdc(12'h01C, 32'h0000_0000);
    // Every select pair on both counters, then random words
    for (int i = 0; i < 48; i++) begin
      seed = lfsr(seed);
      c = seed & 32'h00FF_FFFF;
      if (i < 16) c = {c[31:20], 4'(15 - i), 4'(i), c[11:1], 1'b1};
      seed = lfsr(seed);
      pin <= seed[3:0];
      cfg_a <= seed[7:4];
      cfg_b <= seed[11:8];
      cfg_f <= seed[13:12];
      wr(`CCOM_ADDR_CTRL, c);
      repeat (5) @(posedge clk);
      m = {28'h0, map(c[0] ? c[15:12] : cfg_a, pin[0], pin[1], c[7:4])};
      check(ctrl_a, m);
      m = {28'h0, map(c[0] ? c[19:16] : cfg_b, pin[2], pin[3], c[11:8])};
      check(ctrl_b, m);
      check(freq_mode, 4'b0001 << (c[0] ? c[2:1] : cfg_f));
      check(filter_mode, c[23] ? 3'b100 : (c[22] ? 3'b010 : 3'b001));
      check(thr, c[21:20]);
    end
    // Continuous PWM duty over whole periods
    u = 2 * `CCOM_PRESC_MUL * `CCOM_UNIT_CYC;
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      p = 16'd3 + 16'(seed[17:16]);
      h = (i == 0) ? p : 16'(seed[7:0]) % (p + 16'd1);
      hb = (i == 0) ? 16'h0 : 16'(seed[15:8]) % (p + 16'd1);
      wr(`CCOM_ADDR_PULSE, 32'h0000_0202);
      wr(`CCOM_ADDR_A_PERIOD, {16'h0, p});
      wr(`CCOM_ADDR_A_HIGH, {16'h0, h});
      wr(`CCOM_ADDR_B_PERIOD, {16'h0, p});
      wr(`CCOM_ADDR_B_HIGH, {16'h0, hb});
      wr(`CCOM_ADDR_PULSE, {20'h0, 1'b1, seed[21], 2'b00, 4'h0, 1'b1, seed[20], 2'b00});
      repeat (p * u) @(posedge clk);
      n1 = 0;
      n4 = 0;
      meas <= 1'b1;
      repeat (p * u) @(posedge clk);
      meas <= 1'b0;
      @(posedge clk);
      check(n1, h * u);
      check(n4, hb * u);
      if (i == 0) rdc(`CCOM_ADDR_STATUS, 32'h0000_0001);
    end
    // Route off: ladder bits win over a generator held high
    wr(`CCOM_ADDR_A_HIGH, {16'h0, p});
    wr(`CCOM_ADDR_B_HIGH, {16'h0, p});
    for (int k = 0; k < 2; k++) begin
      wr(`CCOM_ADDR_PULSE, k ? 32'h0000_0010 : 32'h0000_1000);
      repeat (3) @(posedge clk);
      check(out1, k);
      check(out4, 1 - k);
    end
    // One-shot with retrigger during the pulse, both prescales
    wr(`CCOM_ADDR_A_PERIOD, 32'h0000_0008);
    wr(`CCOM_ADDR_B_PERIOD, 32'h0000_0008);
    for (int k = 0; k < 2; k++) begin
      seed = lfsr(seed);
      h = 16'd2 + 16'(seed[1:0]);
      hb = 16'd2 + 16'(seed[3:2]);
      u = k ? `CCOM_UNIT_CYC * `CCOM_PRESC_MUL : `CCOM_UNIT_CYC;
      m = {20'h0, 1'b1, k[0], 2'b10, 4'h0, 1'b1, k[0], 2'b10};
      wr(`CCOM_ADDR_A_HIGH, {16'h0, h});
      wr(`CCOM_ADDR_B_HIGH, {16'h0, hb});
      wr(`CCOM_ADDR_PULSE, m);
      repeat (20) @(posedge clk);
      n1 = 0;
      n4 = 0;
      meas <= 1'b1;
      wr(`CCOM_ADDR_PULSE, m | 32'h0000_0101);
      wr(`CCOM_ADDR_PULSE, m);
      wr(`CCOM_ADDR_PULSE, m | 32'h0000_0101);
      wr(`CCOM_ADDR_PULSE, m);
      repeat (900) @(posedge clk);
      meas <= 1'b0;
      @(posedge clk);
      check(n1, h * u);
      check(n4, hb * u);
    end
    wrap_up();
  end
endmodule // ccom_override_bench
